// [design/adcs_map.vh]
// Register offsets, fields, reset values and timing counts for the sequencer.
// Assumes inclusion by the sequencer files and the sequencer test bench.
`ifndef ADCS_MAP_VH
`define ADCS_MAP_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define ADCS_OFF_CONTROL   12'h000
`define ADCS_OFF_RESULT    12'h004
`define ADCS_OFF_PORTCFG   12'h008
`define ADCS_OFF_STATUS    12'h00C
`define ADCS_OFF_IRQEN     12'h010
`define ADCS_OFF_PORT      12'h014
`define ADCS_OFF_DIR       12'h018

// ****************************************
// Control and status register fields
// ****************************************
`define ADCS_CTL_POWER     0
`define ADCS_CTL_GO        2
`define ADCS_CTL_CHS_LO    3
`define ADCS_CTL_CLK_LO    6
`define ADCS_STS_DONE      6
`define ADCS_STS_WAKE      0

// ****************************************
// Reset values
// ****************************************
`define ADCS_RST_CONTROL   8'h00
`define ADCS_RST_PORTCFG   3'h0
`define ADCS_RST_DIR       6'h3F

// ****************************************
// Clock select codes and timing
// ****************************************
`define ADCS_CLK_DIV2      2'h0
`define ADCS_CLK_DIV8      2'h1
`define ADCS_CLK_DIV32     2'h2
`define ADCS_CLK_RC        2'h3
`define ADCS_HALF_TICKS    5'h13
`define ADCS_RECOVER_TICKS 5'h04
`define ADCS_INSTR_CYCLES  8'h04

`endif

// [design/adcs_period_gen.v]
// Conversion bit period generator: emits half-period ticks.
// Assumes rcTick is already synchronous to clk.
`timescale 1ns/1ps
`include "adcs_map.vh"

module adcs_period_gen
(
  input  wire       clk,
  input  wire       rstn,
  input  wire       clkEn,
  input  wire       run,
  input  wire [1:0] clkSel,
  input  wire       rcTick,
  output reg        halfTick
);

  // ****************************************
  // Divider
  // ****************************************
  reg  [4:0] cnt_q;
  reg  [4:0] limit;

  always @*
  begin
    case (clkSel)
      `ADCS_CLK_DIV2:  limit = 5'h00;
      `ADCS_CLK_DIV8:  limit = 5'h03;
      `ADCS_CLK_DIV32: limit = 5'h0F;
      default:         limit = 5'h00;
    endcase
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q    <= 5'h00;
      halfTick <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!run)
      begin
        cnt_q    <= 5'h00;
        halfTick <= 1'b0;
      end
      else if (clkSel == `ADCS_CLK_RC)
      begin
        cnt_q    <= 5'h00;
        halfTick <= rcTick;
      end
      else if (cnt_q >= limit)
      begin
        cnt_q    <= 5'h00;
        halfTick <= 1'b1;
      end
      else
      begin
        cnt_q    <= cnt_q + 5'h01;
        halfTick <= 1'b0;
      end
    end
  end

endmodule

// [design/adcs_sequencer.v]
// APB-controlled conversion sequencer for an 8-bit successive-approx. ADC.
// Assumes an APB master on clk; the comparator and sleep request are pins.
// Overview of operation
// - Conversion takes 9.5 bit periods from start to result ready.
// - Clock select 00/01/10 gives 2/8/32 clocks; 11 uses RC clock.
// - After completion wait two bit periods, sample switch open.
// - Analog pins need direction input; outputs convert driven level.
// - Channel select and pin direction never gate the sequencing.
// - Port reads return zero for pins configured as analog.
// - Digital-input pins selected still convert their analog level.
// - Clearing go mid-conversion aborts; result stays unchanged.
// - After abort wait two bit periods, then acquire automatically.
// - With RC clock, start is delayed one instruction cycle.
// - Completion clears go and loads the 8-bit result.
// - Completion in sleep with interrupt enabled requests wake-up.
// - Completion in sleep, interrupt off, shuts converter, power stays.
// - Sleep with non-RC clock aborts and shuts off, power bit stays.
// - Completion sets the done flag.
// - With power on, writing go starts; go reads one while busy.
// - Channel select 00..11 picks channels 0..3.
// - Reset turns converter off, aborts, keeps result.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "adcs_map.vh"

module adcs_sequencer
(
  input  wire        clk,
  input  wire        rstn,
  input  wire        clkEn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        sleepReq,
  input  wire        rcClkPin,
  input  wire        cmpIn,
  input  wire [5:0]  pinIn,
  output reg  [1:0]  chanSel,
  output reg         sampleEn,
  output reg         analogOn,
  output reg  [7:0]  dacCode,
  output reg         wakeReq
);

  // ****************************************
  // States
  // ****************************************
  localparam ST_IDLE    = 3'h0;
  localparam ST_DELAY   = 3'h1;
  localparam ST_CONVERT = 3'h2;
  localparam ST_RECOVER = 3'h3;
  localparam ST_OFF     = 3'h4;

  reg  [2:0] state_q;
  reg  [1:0] clkSel_q;
  reg  [1:0] chs_q;
  reg        go_q;
  reg        power_q;
  reg  [7:0] result_q;
  reg  [2:0] portCfg_q;
  reg  [5:0] dir_q;
  reg        done_q;
  reg        irqEn_q;
  reg  [4:0] ticks_q;
  reg  [7:0] delay_q;
  reg  [7:0] sar_q;
  reg  [2:0] bit_q;
  reg        shutdown_q;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg  [2:0] rcS1_q;
  reg  [2:0] rcS2_q;
  reg        slS1_q;
  reg        slS2_q;
  reg  [5:0] pinS1_q;
  reg  [5:0] pinS2_q;
  reg        rcPrev_q;

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rcS1_q   <= 3'h0;
      rcS2_q   <= 3'h0;
      slS1_q   <= 1'b0;
      slS2_q   <= 1'b0;
      pinS1_q  <= 6'h00;
      pinS2_q  <= 6'h00;
      rcPrev_q <= 1'b0;
    end
    else if (clkEn)
    begin
      rcS1_q   <= {rcS1_q[1:0], rcClkPin};
      rcS2_q   <= {rcS2_q[1:0], rcS1_q[0]};
      slS1_q   <= sleepReq;
      slS2_q   <= slS1_q;
      pinS1_q  <= pinIn;
      pinS2_q  <= pinS1_q;
      rcPrev_q <= rcS2_q[0];
    end
  end

  wire rcTick  = rcS2_q[0] ^ rcPrev_q;
  wire sleepS  = slS2_q;
  // Comparator settles within the cycle from dacCode, same clock domain
  wire cmpS    = cmpIn;

  // ****************************************
  // Bit period generator
  // ****************************************
  wire halfTick;
  wire busy = (state_q != ST_IDLE) && (state_q != ST_OFF);

  adcs_period_gen u_period
  (
    .clk      (clk),
    .rstn     (rstn),
    .clkEn    (clkEn),
    .run      (busy),
    .clkSel   (clkSel_q),
    .rcTick   (rcTick),
    .halfTick (halfTick)
  );

  // ****************************************
  // Analog pin decode
  // ****************************************
  function [5:0] analogMask;
    input [2:0] cfg;
    begin
      case (cfg)
        3'h0, 3'h1: analogMask = 6'h17;
        3'h2, 3'h3: analogMask = 6'h07;
        3'h4, 3'h5: analogMask = 6'h03;
        3'h6:       analogMask = 6'h01;
        default:    analogMask = 6'h00;
      endcase
    end
  endfunction

  // ****************************************
  // APB decode
  // ****************************************
  wire access  = psel && penable;
  wire wrEn    = access && pwrite;
  wire wrCtl   = wrEn && (paddr == `ADCS_OFF_CONTROL);
  wire goWr    = pwdata[`ADCS_CTL_GO];
  wire pwrWr   = pwdata[`ADCS_CTL_POWER];
  wire known   = (paddr == `ADCS_OFF_CONTROL) || (paddr == `ADCS_OFF_RESULT) ||
                 (paddr == `ADCS_OFF_PORTCFG) || (paddr == `ADCS_OFF_STATUS) ||
                 (paddr == `ADCS_OFF_IRQEN) || (paddr == `ADCS_OFF_PORT) ||
                 (paddr == `ADCS_OFF_DIR);
  wire [7:0] ctlView = {clkSel_q, 1'b0, chs_q, go_q, 1'b0, power_q};

  // ****************************************
  // Sequencer
  // ****************************************
  wire convEnd  = (state_q == ST_CONVERT) && halfTick &&
                  (ticks_q == `ADCS_HALF_TICKS - 5'h01);
  wire abortReq = busy && (state_q != ST_RECOVER) && wrCtl && !goWr;
  wire sleepOff = sleepS && (clkSel_q != `ADCS_CLK_RC) && busy;

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q    <= ST_IDLE;
      {clkSel_q, chs_q, go_q, power_q} <= 6'h00;
      portCfg_q  <= `ADCS_RST_PORTCFG;
      dir_q      <= `ADCS_RST_DIR;
      done_q     <= 1'b0;
      irqEn_q    <= 1'b0;
      ticks_q    <= 5'h00;
      delay_q    <= 8'h00;
      sar_q      <= 8'h00;
      bit_q      <= 3'h7;
      shutdown_q <= 1'b0;
      wakeReq    <= 1'b0;
    end
    else if (clkEn)
    begin
      if (wrCtl)
      begin
        clkSel_q <= pwdata[`ADCS_CTL_CLK_LO+1:`ADCS_CTL_CLK_LO];
        chs_q    <= pwdata[`ADCS_CTL_CHS_LO+1:`ADCS_CTL_CHS_LO];
        power_q  <= pwrWr;
        go_q     <= goWr && pwrWr && power_q;
        shutdown_q <= 1'b0;
      end
      if (wrEn && paddr == `ADCS_OFF_PORTCFG)
        portCfg_q <= pwdata[2:0];
      if (wrEn && paddr == `ADCS_OFF_DIR)
        dir_q <= pwdata[5:0];
      if (wrEn && paddr == `ADCS_OFF_IRQEN)
        irqEn_q <= pwdata[0];
      if (wrEn && paddr == `ADCS_OFF_STATUS && pwdata[`ADCS_STS_DONE])
        done_q <= 1'b0;
      if (!sleepS)
        wakeReq <= 1'b0;
      case (state_q)
        ST_IDLE, ST_OFF:
        begin
          ticks_q <= 5'h00;
          bit_q   <= 3'h7;
          sar_q   <= 8'h80;
          if (state_q == ST_OFF && !shutdown_q)
            state_q <= ST_IDLE;
          if (wrCtl && goWr && pwrWr && power_q && !shutdown_q)
          begin
            if (clkSel_q == `ADCS_CLK_RC)
            begin
              state_q <= ST_DELAY;
              delay_q <= `ADCS_INSTR_CYCLES - 8'h01;
            end
            else
              state_q <= ST_CONVERT;
          end
        end
        ST_DELAY:
        begin
          if (delay_q == 8'h00)
            state_q <= ST_CONVERT;
          else
            delay_q <= delay_q - 8'h01;
        end
        ST_CONVERT:
        begin
          if (halfTick)
          begin
            ticks_q <= ticks_q + 5'h01;
            if (ticks_q[0] && ticks_q >= 5'h03 && ticks_q <= 5'h11)
            begin
              sar_q[bit_q] <= cmpS;
              if (bit_q != 3'h0)
              begin
                sar_q[bit_q - 3'h1] <= 1'b1;
                bit_q <= bit_q - 3'h1;
              end
            end
          end
          if (convEnd)
          begin
            state_q <= ST_RECOVER;
            ticks_q <= 5'h00;
            go_q    <= 1'b0;
            done_q  <= 1'b1;
            if (sleepS && irqEn_q)
              wakeReq <= 1'b1;
            else if (sleepS)
              shutdown_q <= 1'b1;
          end
        end
        ST_RECOVER:
        begin
          if (halfTick)
            ticks_q <= ticks_q + 5'h01;
          if (halfTick && ticks_q == `ADCS_RECOVER_TICKS - 5'h01)
            state_q <= shutdown_q ? ST_OFF : ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
      if (abortReq)
      begin
        state_q <= ST_RECOVER;
        ticks_q <= 5'h00;
        go_q    <= 1'b0;
      end
      if (sleepOff)
      begin
        state_q    <= ST_OFF;
        go_q       <= 1'b0;
        shutdown_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Result register, no reset
  // ****************************************
  always @(posedge clk)
  begin
    if (clkEn)
    begin
      if (convEnd)
        result_q <= sar_q;
      else if (wrEn && paddr == `ADCS_OFF_RESULT)
        result_q <= pwdata[7:0];
    end
  end

  // ****************************************
  // Analog outputs and APB answer
  // ****************************************
  wire [5:0] portView = pinS2_q & ~analogMask(portCfg_q);

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      chanSel  <= 2'h0;
      sampleEn <= 1'b0;
      analogOn <= 1'b0;
      dacCode  <= 8'h00;
      pready   <= 1'b0;
      prdata   <= 32'h0000_0000;
      pslverr  <= 1'b0;
    end
    else if (clkEn)
    begin
      chanSel  <= chs_q;
      sampleEn <= power_q && !shutdown_q &&
                  (state_q == ST_IDLE);
      analogOn <= power_q && !shutdown_q;
      dacCode  <= sar_q;
      pready   <= psel && !penable;
      pslverr  <= psel && !penable && !known;
      prdata   <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          `ADCS_OFF_CONTROL: prdata <= {24'h000000, ctlView};
          `ADCS_OFF_RESULT:  prdata <= {24'h000000, result_q};
          `ADCS_OFF_PORTCFG: prdata <= {29'h0, portCfg_q};
          `ADCS_OFF_STATUS:  prdata <= {25'h0, done_q, 5'h00, wakeReq};
          `ADCS_OFF_IRQEN:   prdata <= {31'h0, irqEn_q};
          `ADCS_OFF_PORT:    prdata <= {26'h0, portView};
          `ADCS_OFF_DIR:     prdata <= {26'h0, dir_q};
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// [verif/adcs_analog_model.sv]
// Analog side: four channel levels, hold capacitor, comparator, RC clock.
// Assumes levels holds channel n in bits 8n+7:8n.
`timescale 1ns/1ps
module adcs_analog_model
#(
  parameter RC_HALF_NS = 30
)
(
  input  wire        clk,
  input  wire [1:0]  chanSel,
  input  wire        sampleEn,
  input  wire        analogOn,
  input  wire [7:0]  dacCode,
  input  wire [31:0] levels,
  output reg         cmpIn,
  output reg         rcClkPin
);
  reg [7:0] held_q;
  reg       noise_q;

  initial
  begin
    rcClkPin = 1'b0;
    noise_q  = 1'b0;
    held_q   = 8'h00;
    forever #(RC_HALF_NS) rcClkPin = ~rcClkPin;
  end

  always @(posedge clk)
  begin
    noise_q <= ~noise_q;
    if (sampleEn)
      held_q <= levels[chanSel*8 +: 8];
  end

  always @*
    cmpIn = analogOn ? (held_q >= dacCode) : noise_q;
endmodule

// [verif/adcs_seq_checker.sv]
// Checker for the sequencer's bus and converter pins.
// Assumes binding to adcs_sequencer, one clock domain.
`timescale 1ns/1ps
module adcs_seq_checker
(
  input wire        clk,
  input wire        rstn,
  input wire        clkEn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        sleepReq,
  input wire [1:0]  chanSel,
  input wire        sampleEn,
  input wire        analogOn,
  input wire        wakeReq
);
  wire       acc = psel && penable && pready;
  wire       wr  = acc && pwrite && !pslverr;
  reg  [7:0] ctl_q;
  reg        irqEn_q;

  always @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      ctl_q   <= 8'h00;
      irqEn_q <= 1'b0;
    end
    else if (wr && paddr == 12'h000)
      ctl_q <= pwdata[7:0];
    else if (wr && paddr == 12'h010)
      irqEn_q <= pwdata[0];

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_apb_answer: assert property (psel && !penable && clkEn |=> pready)
    else $error("setup without answer");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  chk_err_decode: assert property (acc |->
    pslverr == (paddr > 12'h018 || paddr[1:0] != 2'h0))
    else $error("error response wrong");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_chan_follow: assert property
    (wr && paddr == 12'h000 |=> ##1 chanSel == $past(pwdata[4:3], 2))
    else $error("channel not followed");
  chk_power_gate: assert property
    (wr && paddr == 12'h000 && !pwdata[0] |=> ##1 !analogOn)
    else $error("converter on with power bit clear");
  chk_reset_off: assert property ($rose(rstn) |-> !analogOn && !sampleEn)
    else $error("converter on after reset");
  chk_div2_length: assert property
    ($fell(sampleEn) && analogOn && ctl_q[7:6] == 2'h0 && ctl_q[2] |->
     (!sampleEn throughout ##20 1'b1) ##[1:12] sampleEn)
    else $error("conversion span wrong");
  chk_wake_cause: assert property
    ($rose(wakeReq) |-> irqEn_q && ctl_q[7:6] == 2'h3)
    else $error("wake without cause");
  chk_wake_drop: assert property ((!sleepReq)[*5] |-> !wakeReq)
    else $error("wake held while awake");
  chk_sleep_abort: assert property
    ((sleepReq && ctl_q[7:6] != 2'h3)[*5] |-> !analogOn)
    else $error("converter on in sleep");
endmodule

// [verif/adcs_sequencer_test.sv]
// Self-checking bench for the conversion sequencer.
// Assumes the analog model drives the comparator and RC clock pins.
`timescale 1ns/1ps
`include "adcs_map.vh"
module adcs_sequencer_test;
  reg         clk;
  reg         rstn;
  reg         clkEn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata;
  reg         sleepReq;
  reg  [5:0]  pinIn;
  reg  [31:0] levels;
  wire        pready;
  wire [31:0] prdata;
  wire        pslverr;
  wire        rcClkPin;
  wire        cmpIn;
  wire [1:0]  chanSel;
  wire        sampleEn;
  wire        analogOn;
  wire [7:0]  dacCode;
  wire        wakeReq;
  wire [2:0]  mon = {wakeReq, analogOn, sampleEn};
  integer     err_count;
  integer     samples_checked;
  integer     seed;
  integer     i;
  integer     n;
  integer     cyc;
  integer     t0;
  reg  [31:0] rd;
  reg  [31:0] rnd;
  reg  [31:0] ctl;
  reg         rdErr;
  reg  [7:0]  lv;
  reg  [7:0]  last;

  adcs_sequencer uut (.clk, .rstn, .clkEn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .sleepReq, .rcClkPin,
    .cmpIn, .pinIn, .chanSel, .sampleEn, .analogOn, .dacCode, .wakeReq);
  adcs_analog_model model (.clk, .chanSel, .sampleEn, .analogOn,
    .dacCode, .levels, .cmpIn, .rcClkPin);

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
    cyc <= cyc + 1;

  // ****
  // Shared tasks
  // ****
  task chkVal;
    input [127:0] nm;
    input [31:0] exp;
    input [31:0] got;
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("mismatch %0s exp %h got %h", nm, exp, got);
    end
  end
  endtask

  task apb;
    input        w;
    input [11:0] a;
    input [31:0] d;
    integer      k;
  begin
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    @(posedge clk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k = k + 1;
    end
    if (k == 20)
      err_count = err_count + 1;
    rd      = prdata;
    rdErr   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  end
  endtask

  task waitLevel;
    input [1:0] s;
    input       v;
  begin
    n = 0;
    while (mon[s] !== v && n < 3000)
    begin
      @(posedge clk);
      n = n + 1;
    end
  end
  endtask

  function [31:0] portExp;
    input [2:0] cfg;
    input [5:0] pins;
    reg   [5:0] m;
  begin
    case (cfg[2:1])
      2'h0: m = 6'h17;
      2'h1: m = 6'h07;
      2'h2: m = 6'h03;
      default: m = cfg[0] ? 6'h00 : 6'h01;
    endcase
    portExp = {26'h0, pins & ~m};
  end
  endfunction

  task prep;
    input [1:0] cs;
    input [1:0] ch;
  begin
    rnd = $random(seed);
    lv = rnd[7:0];
    levels[ch*8 +: 8] <= lv;
    pinIn <= rnd[13:8];
    apb(1, `ADCS_OFF_DIR, $random(seed));
    apb(1, `ADCS_OFF_STATUS, 32'h40);
    ctl = {24'h0, cs, 1'b0, ch, 3'h1};
    apb(1, `ADCS_OFF_CONTROL, ctl);
    repeat (100) @(posedge clk);
    apb(1, `ADCS_OFF_CONTROL, ctl | 32'h4);
    t0 = cyc;
  end
  endtask

  task convert;
    input [1:0] cs;
    input [1:0] ch;
  begin
    prep(cs, ch);
    apb(0, `ADCS_OFF_CONTROL, 0);
    chkVal("go busy", 32'h4, rd & 32'h4);
    while (rd[2] && cyc - t0 < 2000)
      apb(0, `ADCS_OFF_CONTROL, 0);
    chkVal("go clear", 32'h0, rd & 32'h4);
    if (cs != 2'h3)
      chkVal("span", 1, cyc - t0 >= (19 << (2 * cs)) - 3 &&
        cyc - t0 <= (19 << (2 * cs)) + 12);
    apb(0, `ADCS_OFF_RESULT, 0);
    chkVal("result", lv, rd);
    apb(0, `ADCS_OFF_STATUS, 0);
    chkVal("done flag", 32'h40, rd & 32'h40);
  end
  endtask

  task tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask

  // ****
  // Scenarios
  // ****
  initial
  begin
    seed = 32'h04FA91E7;
    err_count = 0;
    samples_checked = 0;
    cyc = 0;
    rstn = 1'b0;
    clkEn = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sleepReq = 1'b0;
    pinIn = 6'h00;
    levels = 32'h0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(0, `ADCS_OFF_CONTROL, 0);
    chkVal("control", 32'h0, rd);
    apb(0, `ADCS_OFF_DIR, 0);
    chkVal("direction", 32'h3F, rd);
    for (i = 0; i < 8; i = i + 1)
    begin
      rnd = $random(seed);
      pinIn <= rnd[5:0];
      apb(1, `ADCS_OFF_PORTCFG, i);
      apb(0, `ADCS_OFF_PORT, 0);
      chkVal("port", portExp(i, pinIn), rd);
    end
    apb(1, 12'h01C, 32'hFF);
    chkVal("slverr", 1, rdErr);
    apb(0, 12'h01C, 0);
    chkVal("unmapped", 0, rd);
    apb(1, `ADCS_OFF_RESULT, 32'hA5);
    apb(0, `ADCS_OFF_RESULT, 0);
    chkVal("result wr", 32'hA5, rd);
    apb(1, `ADCS_OFF_CONTROL, 32'h04);
    apb(0, `ADCS_OFF_CONTROL, 0);
    chkVal("go unpowered", 32'h0, rd);
    apb(1, `ADCS_OFF_CONTROL, 32'h05);
    apb(0, `ADCS_OFF_CONTROL, 0);
    chkVal("go with power", 32'h1, rd);
    $display("test registers done");
    for (i = 0; i < 16; i = i + 1)
      convert(i[1:0], i[3:2]);
    $display("test conversions done");
    apb(1, `ADCS_OFF_IRQEN, 1);
    prep(2'h3, 2'h2);
    @(negedge clk);
    chkVal("rc delay", 0, sampleEn);
    @(posedge clk);
    sleepReq <= 1'b1;
    waitLevel(2, 1);
    chkVal("wake", 1, wakeReq);
    sleepReq <= 1'b0;
    apb(0, `ADCS_OFF_RESULT, 0);
    chkVal("sleep result", lv, rd);
    apb(1, `ADCS_OFF_IRQEN, 0);
    prep(2'h3, 2'h1);
    sleepReq <= 1'b1;
    waitLevel(1, 0);
    chkVal("shut off", 0, analogOn);
    apb(0, `ADCS_OFF_CONTROL, 0);
    chkVal("power kept", 1, rd & 32'h1);
    sleepReq <= 1'b0;
    last = lv;
    prep(2'h1, 2'h3);
    sleepReq <= 1'b1;
    waitLevel(1, 0);
    chkVal("sleep abort", 1, n < 10);
    apb(0, `ADCS_OFF_CONTROL, 0);
    chkVal("power stays", 1, rd & 32'h1);
    apb(0, `ADCS_OFF_RESULT, 0);
    chkVal("abort keep", last, rd);
    sleepReq <= 1'b0;
    $display("test sleep done");
    prep(2'h2, 2'h0);
    repeat (50) @(posedge clk);
    apb(1, `ADCS_OFF_CONTROL, ctl);
    waitLevel(0, 1);
    chkVal("recovery", 1, n >= 48 && n <= 80);
    apb(0, `ADCS_OFF_RESULT, 0);
    chkVal("abort result", last, rd);
    apb(0, `ADCS_OFF_STATUS, 0);
    chkVal("abort flag", 0, rd & 32'h40);
    prep(2'h2, 2'h1);
    repeat (50) @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(0, `ADCS_OFF_CONTROL, 0);
    chkVal("reset ctl", 0, rd);
    apb(0, `ADCS_OFF_RESULT, 0);
    chkVal("reset keep", last, rd);
    $display("test abort and reset done");
    tally_and_finish;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count = err_count + 1;
    tally_and_finish;
  end
endmodule

bind adcs_sequencer adcs_seq_checker chk (.clk, .rstn, .clkEn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
  .sleepReq, .chanSel, .sampleEn, .analogOn, .wakeReq);
